// ==== src/ckdp_dev.sv ====
// Purpose: device end, key detection and direct programming interpreter
// Assumes: nonvolatile loader sits outside, gives disable bits
// Notes: one part per system when the vendor key is used
`include "ckdp_regs.svh"
`default_nettype none
module ckdp_dev #(
   parameter int NLDEV = `CKDP_NUM_LDEV
) (
   input wire logic mclk,
   input wire logic rst,
   ckdp_if.dev lnk,
   input wire logic nv_std_key_dis,
   input wire logic nv_vnd_key_dis,
   output logic cfg_mode,
   output logic std_mode,
   output logic chip_active,
   output logic hostload_ok,
   output logic [7:0] card_sel,
   output logic std_key_dis,
   output logic vnd_key_dis,
   output logic [NLDEV-1:0] ldev_respond,
   output ckdp_pkg::ckdp_ldev_s [NLDEV-1:0] ldev_cfg
);
   typedef struct packed {
      logic [5:0] vidx;
      logic [5:0] sidx;
      logic [7:0] lfsr;
      logic cfg_mode;
      logic std_mode;
      logic chip_active;
      logic std_dis;
      logic vnd_dis;
      ckdp_pkg::ckdp_phase_e ph;
      logic [7:0] cmd;
      logic [7:0] hi;
      logic [2:0] ldn;
      logic [7:0] csn;
      ckdp_pkg::ckdp_ldev_s [NLDEV-1:0] dev;
   } ckdp_dev_s;
   ckdp_dev_s s_r, s_nxt;

   // ----
   // Key generators
   // ----
   // Both keys share one shift generator, seeds differ
   function automatic logic [7:0] step(input logic [7:0] k);
      return {k[0] ^ k[1], k[7:1]};
   endfunction

   // Vendor key breaks the shift rule at its first byte only
   function automatic logic [7:0] vkey_byte(input logic [5:0] i);
      logic [7:0] k;
      k = `CKDP_VND_KEY1;
      for (int j = 1; j < `CKDP_KEY_LEN; j++) begin
         if (j[5:0] < i) k = step(k);
      end
      if (i == 6'd0) k = `CKDP_VND_KEY0;
      return k;
   endfunction

   // Number of argument bytes for a command
   function automatic logic [1:0] nargs(input logic [7:0] c);
      case (c)
         `CKDP_CMD_IO0, `CKDP_CMD_IO1, `CKDP_CMD_IO2: nargs = 2'd2;
         `CKDP_CMD_CSN, `CKDP_CMD_LDN, `CKDP_CMD_IRQ0, `CKDP_CMD_IRQ1,
         `CKDP_CMD_DMA0, `CKDP_CMD_DMA1, `CKDP_CMD_ACT: nargs = 2'd1;
         default: nargs = 2'd0;
      endcase
   endfunction

   logic [7:0] vexp;
   logic [7:0] sexp;
   logic vkey_dis, skey_dis;

   always_comb begin
      vexp = vkey_byte(s_r.vidx);
      sexp = s_r.lfsr;
      // Nonvolatile disables honoured alongside direct ones
      vkey_dis = s_r.vnd_dis | nv_vnd_key_dis;
      skey_dis = s_r.std_dis | nv_std_key_dis;
   end

   // ----
   // Key matchers and command interpreter
   // ----
   always_comb begin
      s_nxt = s_r;
      if (lnk.cfg_wr) begin
         // Vendor key match in order, restart on mismatch
         if (!vkey_dis) begin
            if (lnk.cfg_data == vexp) begin
               s_nxt.vidx = s_r.vidx + 6'd1;
               if (s_r.vidx == `CKDP_KEY_LEN - 6'd1) begin
                  s_nxt.vidx = 6'd0;
                  s_nxt.cfg_mode = 1'b1;
                  s_nxt.ph = ckdp_pkg::CKDP_ST_CMD;
               end
            end else begin
               s_nxt.vidx =
                  (lnk.cfg_data == `CKDP_VND_KEY0) ? 6'd1 : 6'd0;
            end
         end
         // Standard key, same port
         if (!skey_dis) begin
            if (lnk.cfg_data == sexp) begin
               s_nxt.sidx = s_r.sidx + 6'd1;
               s_nxt.lfsr = step(s_r.lfsr);
               if (s_r.sidx == `CKDP_KEY_LEN - 6'd1) begin
                  s_nxt.sidx = 6'd0;
                  s_nxt.lfsr = `CKDP_STD_SEED;
                  s_nxt.std_mode = 1'b1;
               end
            end else begin
               s_nxt.sidx = 6'd0;
               s_nxt.lfsr = `CKDP_STD_SEED;
            end
         end
         if (s_r.cfg_mode) begin
            case (s_r.ph)
               ckdp_pkg::CKDP_ST_CMD: begin
                  s_nxt.cmd = lnk.cfg_data;
                  if (lnk.cfg_data == `CKDP_CMD_CHIP) begin
                     s_nxt.chip_active = 1'b1;
                     s_nxt.cfg_mode = 1'b0;
                  end else if (nargs(lnk.cfg_data) != 2'd0) begin
                     s_nxt.ph = ckdp_pkg::CKDP_ST_ARG1;
                  end
               end
               ckdp_pkg::CKDP_ST_ARG1: begin
                  s_nxt.ph = ckdp_pkg::CKDP_ST_CMD;
                  case (s_r.cmd)
                     `CKDP_CMD_CSN: s_nxt.csn = lnk.cfg_data;
                     `CKDP_CMD_LDN: begin
                        // Out-of-range numbers ignored
                        if (lnk.cfg_data <= {5'h00, `CKDP_MAX_LDEV})
                           s_nxt.ldn = lnk.cfg_data[2:0];
                     end
                     `CKDP_CMD_IO0, `CKDP_CMD_IO1, `CKDP_CMD_IO2: begin
                        s_nxt.hi = lnk.cfg_data;
                        s_nxt.ph = ckdp_pkg::CKDP_ST_ARG2;
                     end
                     `CKDP_CMD_IRQ0:
                        s_nxt.dev[s_r.ldn].irq0 = lnk.cfg_data;
                     `CKDP_CMD_IRQ1:
                        s_nxt.dev[s_r.ldn].irq1 = lnk.cfg_data;
                     `CKDP_CMD_DMA0:
                        s_nxt.dev[s_r.ldn].dma0 = lnk.cfg_data;
                     `CKDP_CMD_DMA1:
                        s_nxt.dev[s_r.ldn].dma1 = lnk.cfg_data;
                     `CKDP_CMD_ACT: begin
                        if (lnk.cfg_data == `CKDP_ACT_ON)
                           s_nxt.dev[s_r.ldn].active = 1'b1;
                        else if (lnk.cfg_data == `CKDP_ACT_OFF)
                           s_nxt.dev[s_r.ldn].active = 1'b0;
                     end
                     default: ;
                  endcase
               end
               ckdp_pkg::CKDP_ST_ARG2: begin
                  s_nxt.ph = ckdp_pkg::CKDP_ST_CMD;
                  case (s_r.cmd)
                     `CKDP_CMD_IO0:
                        s_nxt.dev[s_r.ldn].io0 = {s_r.hi, lnk.cfg_data};
                     `CKDP_CMD_IO1:
                        s_nxt.dev[s_r.ldn].io1 = {s_r.hi, lnk.cfg_data};
                     `CKDP_CMD_IO2:
                        s_nxt.dev[s_r.ldn].io2 = {s_r.hi, lnk.cfg_data};
                     default: ;
                  endcase
               end
               default: s_nxt.ph = ckdp_pkg::CKDP_ST_CMD;
            endcase
         end
      end
      // Control block writes; sticky until reset
      if (lnk.ctl_wr && lnk.ctl_ofs == `CKDP_CTRL_OFS) begin
         if (lnk.ctl_data == `CKDP_DIS_STD) begin
            s_nxt.std_dis = 1'b1;
            s_nxt.std_mode = 1'b0;
            s_nxt.sidx = 6'd0;
         end
         if (lnk.ctl_data == `CKDP_DIS_VND) begin
            s_nxt.vnd_dis = 1'b1;
            s_nxt.vidx = 6'd0;
         end
      end
      // Either disable source blocks standard mode
      if (skey_dis) s_nxt.std_mode = 1'b0;
   end

   // ----
   // State register
   // ----
   always_ff @(posedge mclk) begin
      if (rst) begin
         s_r <= '0;
         s_r.lfsr <= `CKDP_STD_SEED;
      end else begin
         s_r <= s_nxt;
      end
   end

   // ----
   // Outputs
   // ----
   // Resources kept regardless of key disables
   for (genvar g = 0; g < NLDEV; g++) begin : g_resp
      assign ldev_respond[g] = s_r.chip_active & s_r.dev[g].active;
   end

   assign cfg_mode = s_r.cfg_mode;
   assign std_mode = s_r.std_mode;
   assign chip_active = s_r.chip_active;
   assign hostload_ok = s_r.cfg_mode;
   assign card_sel = s_r.csn;
   assign std_key_dis = skey_dis;
   assign vnd_key_dis = vkey_dis;
   assign ldev_cfg = s_r.dev;
endmodule
`default_nettype wire

// ==== src/ckdp_regs.svh ====
// Purpose: constants for the configuration key and direct programming block
// Assumes: byte writes from the host arrive as one-cycle strobes
// Notes: timing-free; the key length is a byte count, CKDP_NUM_LDEV counts devices, CKDP_MAX_LDEV is the highest device number
`ifndef CKDP_REGS_SVH
`define CKDP_REGS_SVH
`define CKDP_KEY_LEN 6'd32
`define CKDP_VND_KEY0 8'h96
`define CKDP_VND_KEY1 8'h35
`define CKDP_CMD_CSN 8'h06
`define CKDP_CMD_LDN 8'h15
`define CKDP_CMD_IO0 8'h47
`define CKDP_CMD_IO1 8'h48
`define CKDP_CMD_IO2 8'h42
`define CKDP_CMD_IRQ0 8'h22
`define CKDP_CMD_IRQ1 8'h27
`define CKDP_CMD_DMA0 8'h2A
`define CKDP_CMD_DMA1 8'h25
`define CKDP_CMD_ACT 8'h33
`define CKDP_CMD_CHIP 8'h79
`define CKDP_ACT_ON 8'h01
`define CKDP_ACT_OFF 8'h00
`define CKDP_CTRL_OFS 3'h5
`define CKDP_DIS_STD 8'h55
`define CKDP_DIS_VND 8'h56
`define CKDP_NUM_LDEV 6
`define CKDP_MAX_LDEV 3'h5
`define CKDP_STD_SEED 8'h6A
`endif

// ==== src/ckdp_pkg.sv ====
// Purpose: types for the device end of the key and programming link
// Assumes: ckdp_regs.svh holds the numbers
// Notes: per-device configuration record
`default_nettype none
package ckdp_pkg;
   typedef struct packed {
      logic [15:0] io0;
      logic [15:0] io1;
      logic [15:0] io2;
      logic [7:0] irq0;
      logic [7:0] irq1;
      logic [7:0] dma0;
      logic [7:0] dma1;
      logic active;
   } ckdp_ldev_s;
   typedef enum logic [3:0] {
      CKDP_ST_CMD, CKDP_ST_ARG1, CKDP_ST_ARG2
   } ckdp_phase_e;
endpackage
`default_nettype wire

// ==== src/ckdp_if.sv ====
// Purpose: byte-write link between host and device
// Assumes: one byte per cycle at most, strobe is a pulse
// Notes: cfg_* is the address port, ctl_* the control block
`default_nettype none
interface ckdp_if;
   logic cfg_wr;
   logic [7:0] cfg_data;
   logic ctl_wr;
   logic [2:0] ctl_ofs;
   logic [7:0] ctl_data;
   modport host (output cfg_wr, output cfg_data, output ctl_wr,
      output ctl_ofs, output ctl_data);
   modport dev (input cfg_wr, input cfg_data, input ctl_wr,
      input ctl_ofs, input ctl_data);
endinterface
`default_nettype wire

// ==== src/ckdp_host.sv ====
// Purpose: host end, sends key and direct programming byte stream
// Assumes: user gives one request at a time while busy is low
// Notes: serialises the key on request, passes single bytes straight through; the caller keeps the order
`include "ckdp_regs.svh"
`default_nettype none
module ckdp_host (
   input wire logic mclk,
   input wire logic rst,
   ckdp_if.host lnk,
   input wire logic send_key,
   input wire logic send_byte,
   input wire logic [7:0] byte_in,
   input wire logic send_ctl,
   input wire logic [7:0] ctl_in,
   output logic busy
);
   typedef struct packed {
      logic keying;
      logic [5:0] idx;
      logic cfg_wr;
      logic [7:0] cfg_data;
      logic ctl_wr;
      logic [7:0] ctl_data;
   } ckdp_host_s;
   ckdp_host_s s_r, s_nxt;

   // First byte is fixed; the shift rule only runs from the second
   function automatic logic [7:0] key_byte(input logic [5:0] i);
      logic [7:0] k;
      k = `CKDP_VND_KEY1;
      for (int j = 1; j < `CKDP_KEY_LEN; j++) begin
         if (j[5:0] < i) k = {k[0] ^ k[1], k[7:1]};
      end
      if (i == 6'd0) k = `CKDP_VND_KEY0;
      return k;
   endfunction

   always_comb begin
      s_nxt = s_r;
      s_nxt.cfg_wr = 1'b0;
      s_nxt.ctl_wr = 1'b0;
      if (s_r.keying) begin
         // Key bytes strictly in order
         s_nxt.cfg_wr = 1'b1;
         s_nxt.cfg_data = key_byte(s_r.idx);
         s_nxt.idx = s_r.idx + 6'd1;
         if (s_r.idx == `CKDP_KEY_LEN - 6'd1) s_nxt.keying = 1'b0;
      end else if (send_key) begin
         s_nxt.keying = 1'b1;
         s_nxt.idx = 6'd0;
      end else if (send_byte) begin
         // Caller keeps key, card select, devices, activate order
         s_nxt.cfg_wr = 1'b1;
         s_nxt.cfg_data = byte_in;
      end else if (send_ctl) begin
         s_nxt.ctl_wr = 1'b1;
         s_nxt.ctl_data = ctl_in;
      end
   end

   always_ff @(posedge mclk) begin
      if (rst) s_r <= '0;
      else s_r <= s_nxt;
   end

   assign lnk.cfg_wr = s_r.cfg_wr;
   assign lnk.cfg_data = s_r.cfg_data;
   assign lnk.ctl_wr = s_r.ctl_wr;
   assign lnk.ctl_ofs = `CKDP_CTRL_OFS;
   assign lnk.ctl_data = s_r.ctl_data;
   assign busy = s_r.keying;
endmodule
`default_nettype wire

// ==== verif/ckdp_properties.sv ====
// Purpose: timing checks on the key and programming link
// Assumes: one clock domain, synchronous reset
// Notes: device state outputs are watched beside the link
`default_nettype none
module ckdp_properties #(
   parameter int NLDEV = 6
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic cfg_wr,
   input wire logic [7:0] cfg_data,
   input wire logic ctl_wr,
   input wire logic [2:0] ctl_ofs,
   input wire logic [7:0] ctl_data,
   input wire logic nv_std_key_dis,
   input wire logic nv_vnd_key_dis,
   input wire logic cfg_mode,
   input wire logic std_mode,
   input wire logic chip_active,
   input wire logic hostload_ok,
   input wire logic [7:0] card_sel,
   input wire logic std_key_dis,
   input wire logic vnd_key_dis,
   input wire logic [NLDEV-1:0] ldev_respond
);
   logic rst_d;
   // Reset seen one edge late: the edge after release still shows
   // the values that reset has just cleared
   always_ff @(posedge mclk) rst_d <= rst;
   default clocking @(posedge mclk); endclocking
   default disable iff (rst || rst_d);
   // ----
   // Checks
   // ----
   key_entry_a: assert property ($rose(cfg_mode) |->
      $past(cfg_wr && cfg_data == 8'h1A && !vnd_key_dis))
      else $error("config mode entered without last key byte");
   csn_src_a: assert property ($changed(card_sel) |->
      $past(cfg_wr && cfg_mode))
      else $error("card select moved without a config write");
   chip_on_a: assert property ($rose(chip_active) |->
      $past(cfg_wr && cfg_data == 8'h79 && cfg_mode) && !cfg_mode)
      else $error("chip activation without its byte");
   vnd_dis_a: assert property ($rose(vnd_key_dis) |->
      nv_vnd_key_dis ||
      $past(ctl_wr && ctl_ofs == 3'h5 && ctl_data == 8'h56))
      else $error("vendor key disabled without cause");
   std_dis_a: assert property ($rose(std_key_dis) |->
      nv_std_key_dis ||
      $past(ctl_wr && ctl_ofs == 3'h5 && ctl_data == 8'h55))
      else $error("standard key disabled without cause");
   vnd_hold_a: assert property ($fell(vnd_key_dis) |->
      !nv_vnd_key_dis && $past(nv_vnd_key_dis))
      else $error("vendor key disable dropped before reset");
   std_drop_a: assert property (std_key_dis |=> !std_mode)
      else $error("standard mode kept while key disabled");
   load_ok_a: assert property (hostload_ok == cfg_mode)
      else $error("host download gate differs from config mode");
   respond_gate_a: assert property (|ldev_respond |->
      chip_active)
      else $error("device answers before chip activation");
endmodule
`default_nettype wire

// ==== verif/testbench.sv ====
// Purpose: self-checking bench, host and device ends joined
// Assumes: host link outputs are registered
// Notes: expected values worked out here, never read back
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic send_key = 1'b0;
   logic send_byte = 1'b0;
   logic send_ctl = 1'b0;
   logic [7:0] byte_in = 8'h00;
   logic [7:0] ctl_in = 8'h00;
   logic nv_std = 1'b0;
   logic nv_vnd = 1'b0;
   logic busy, cfg_mode, std_mode, chip_active, hostload_ok;
   logic std_key_dis, vnd_key_dis;
   logic [7:0] card_sel;
   logic [5:0] ldev_respond;
   ckdp_pkg::ckdp_ldev_s [5:0] ldev_cfg;
   int n_fail = 0;
   int checks_done = 0;
   int cyc = 0;
   always #5 mclk = ~mclk;
   ckdp_if ckdp_if_inst ();
   ckdp_host ckdp_host_inst (.mclk(mclk), .rst(rst), .lnk(ckdp_if_inst),
      .send_key(send_key), .send_byte(send_byte), .byte_in(byte_in),
      .send_ctl(send_ctl), .ctl_in(ctl_in), .busy(busy));
   // A single device on the link
   ckdp_dev ckdp_dev_inst (.mclk(mclk), .rst(rst), .lnk(ckdp_if_inst),
      .nv_std_key_dis(nv_std), .nv_vnd_key_dis(nv_vnd),
      .cfg_mode(cfg_mode), .std_mode(std_mode),
      .chip_active(chip_active), .hostload_ok(hostload_ok),
      .card_sel(card_sel), .std_key_dis(std_key_dis),
      .vnd_key_dis(vnd_key_dis), .ldev_respond(ldev_respond),
      .ldev_cfg(ldev_cfg));
   ckdp_properties #(.NLDEV(6)) ckdp_properties_inst (.mclk(mclk),
      .rst(rst), .cfg_wr(ckdp_if_inst.cfg_wr),
      .cfg_data(ckdp_if_inst.cfg_data), .ctl_wr(ckdp_if_inst.ctl_wr),
      .ctl_ofs(ckdp_if_inst.ctl_ofs), .ctl_data(ckdp_if_inst.ctl_data),
      .nv_std_key_dis(nv_std), .nv_vnd_key_dis(nv_vnd),
      .cfg_mode(cfg_mode), .std_mode(std_mode),
      .chip_active(chip_active), .hostload_ok(hostload_ok),
      .card_sel(card_sel), .std_key_dis(std_key_dis),
      .vnd_key_dis(vnd_key_dis), .ldev_respond(ldev_respond));
   // ----
   // Shared tasks
   // ----
   task automatic tally_and_finish();
      if (n_fail == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 6000) begin
         n_fail++;
         tally_and_finish();
      end
   end
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // Settles past the device's one-cycle answer before returning
   task automatic put(input logic c, input logic [7:0] b);
      @(posedge mclk);
      send_ctl <= c;
      send_byte <= !c;
      byte_in <= b;
      ctl_in <= b;
      @(posedge mclk);
      send_ctl <= 1'b0;
      send_byte <= 1'b0;
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic seq(input logic [7:0] q[$]);
      foreach (q[i]) put(1'b0, q[i]);
   endtask
   // Key bytes by the shift rule; the vendor key uses it from its 2nd byte
   task automatic skey(input logic [7:0] x, input int n);
      repeat (n) begin
         put(1'b0, x);
         x = {x[0] ^ x[1], x[7:1]};
      end
   endtask
   task automatic key();
      int i;
      @(posedge mclk);
      send_key <= 1'b1;
      @(posedge mclk);
      send_key <= 1'b0;
      #1;
      i = 0;
      while (busy !== 1'b0 && i < 40) begin
         @(posedge mclk);
         #1;
         i++;
      end
      chk(16'(i < 40), 16'h0001);
      repeat (2) @(posedge mclk);
      #1;
   endtask
   task automatic rstp();
      @(posedge mclk);
      rst <= 1'b1;
      repeat (2) @(posedge mclk);
      rst <= 1'b0;
   endtask
   // ----
   // Scenarios
   // ----
   task automatic t_prog();
      seq('{8'h96, 8'h35, 8'h00});
      chk(16'(cfg_mode), 16'h0000);
      put(1'b0, 8'h96);
      skey(8'h35, 31);
      chk(16'(cfg_mode), 16'h0001);
      chk(16'(hostload_ok), 16'h0001);
      seq('{8'hE0, 8'h06, 8'h01, 8'h15, 8'h00, 8'h47, 8'h05, 8'h34,
         8'h48, 8'h03, 8'h88, 8'h42, 8'h02, 8'h20, 8'h22, 8'h05, 8'h27, 8'h07,
         8'h2A, 8'h01, 8'h25, 8'h03, 8'h33, 8'h01, 8'h15, 8'h05, 8'h33,
         8'h01, 8'h33, 8'h00, 8'h15, 8'h01, 8'h47, 8'h02, 8'h00, 8'h33,
         8'h01, 8'h15, 8'h07, 8'h47, 8'h0A, 8'hBC});
      chk(16'(card_sel), 16'h0001);
      chk(ldev_cfg[0].io0, 16'h0534);
      chk(ldev_cfg[0].io1, 16'h0388);
      chk(ldev_cfg[0].io2, 16'h0220);
      chk({ldev_cfg[0].irq0, ldev_cfg[0].irq1}, 16'h0507);
      chk({ldev_cfg[0].dma0, ldev_cfg[0].dma1}, 16'h0103);
      chk({ldev_cfg[0].active, ldev_cfg[5].active}, 16'h0002);
      chk(ldev_cfg[1].io0, 16'h0ABC);
      chk(16'(ldev_respond), 16'h0000);
      put(1'b0, 8'h79);
      chk({chip_active, cfg_mode}, 16'h0002);
      chk(16'(ldev_respond), 16'h0003);
      seq('{8'h06, 8'h05});
      chk(16'(card_sel), 16'h0001);
   endtask
   task automatic t_dis();
      put(1'b1, 8'h56);
      chk(16'(vnd_key_dis), 16'h0001);
      key();
      chk(16'(cfg_mode), 16'h0000);
      chk(16'(ldev_respond), 16'h0003);
      skey(8'h6A, 32);
      chk(16'(std_mode), 16'h0001);
      put(1'b1, 8'h55);
      chk({std_key_dis, std_mode}, 16'h0002);
      skey(8'h6A, 32);
      chk(16'(std_mode), 16'h0000);
      rstp();
      #1;
      chk({std_key_dis, vnd_key_dis}, 16'h0000);
      key();
      chk(16'(cfg_mode), 16'h0001);
   endtask
   task automatic t_nv();
      rstp();
      nv_vnd <= 1'b1;
      key();
      chk({vnd_key_dis, cfg_mode}, 16'h0002);
      @(posedge mclk);
      nv_vnd <= 1'b0;
      nv_std <= 1'b1;
      skey(8'h6A, 32);
      chk({std_key_dis, std_mode}, 16'h0002);
      @(posedge mclk);
      nv_std <= 1'b0;
      key();
      chk(16'(cfg_mode), 16'h0001);
   endtask
   initial begin
      repeat (5) @(posedge mclk);
      rst <= 1'b0;
      t_prog();
      t_dis();
      t_nv();
      tally_and_finish();
   end
endmodule
`default_nettype wire
